// ---- rtl/dma_chan.sv ----
`timescale 1ns/1ps
// Functional notes
// - Staging buffer is 128 bytes as two alternating 64-byte halves.
// - First system bus tenure moves at least 128 bytes unless count ends.
// - System-write direction prefetches 128 bytes, or to count end, before any system access.
// - Keep moving until current half done and other half busy elsewhere.
// - Peer channel may use leftover grant when level options match.
// - Control bit 0 enables the channel, bit 1 picks direction.
// - System-read start arbitrates at once and reads up to 128 bytes.
// - First full half drains to local memory while system reads go on.
// - System-read releases after 128 bytes, drains, re-arbitrates until done.
// - System-write fills 128 bytes or count end, then arbitrates.
// - System-write drains while refilling, releases when empty, repeats.
// - Any alignment works; byte enables set bytes moved per cycle.
// - System master moves most bytes per cycle; three at offset 1.
// - Odd start: three bytes, one four-byte cycle, then streaming.
// - Local write at odd address moves three bytes on upper lanes.
// - Local reads fetch whole word, all enables, low address bits zero.
// - Append writes target bits 23..16 to I/O address bits 15..0.
// - Appended write follows the last write to the destination bus.
// - Control bit 7 enables the appended I/O write.
// - Append plus post-status: normal finish, no appended write.
// - Control bit 8 posts the status word to local memory at end.
`include "dma_chan_map.svh"
module dma_chan
	import dma_chan_pkg::*;
(
	input  wire logic        pclk,         // Chip clock, 40 MHz.
	input  wire logic        presetn,      // Asynchronous reset, active low.
	input  wire logic        psel,         // APB select.
	input  wire logic        penable,      // APB access phase.
	input  wire logic        pwrite,       // APB write.
	input  wire logic [11:0] paddr,        // APB byte address.
	input  wire logic [31:0] pwdata,       // APB write data.
	output logic      [31:0] prdata,       // APB read data.
	output logic             pready,       // APB ready.
	output logic             pslverr,      // APB error on unmapped address.
	output logic             sys_req,      // System bus arbitration request.
	input  wire logic        sys_gnt,      // System bus grant.
	output logic             sys_valid,    // System bus cycle request.
	input  wire logic        sys_ready,    // System slave completes the cycle.
	output logic      [31:0] sys_addr,     // System bus address.
	output logic      [3:0]  sys_be,       // System byte enables.
	output logic             sys_write,    // System cycle is a write.
	output logic             sys_io,       // System cycle is an I/O write.
	output logic             sys_stream,   // System cycle may stream.
	output logic      [31:0] sys_wdata,    // System write data.
	input  wire logic [31:0] sys_rdata,    // System read data.
	output logic             share_out,    // Grant time left for the peer.
	input  wire logic        share_in,     // Peer offers its grant time.
	output logic             level_out,    // Own arbitration level option.
	input  wire logic        peer_level,   // Peer arbitration level option.
	output logic             lb_valid,     // Local bus cycle request.
	input  wire logic        lb_ready,     // Local slave completes the cycle.
	output logic      [31:0] lb_addr,      // Local word address.
	output logic      [3:0]  lb_be,        // Local byte enables.
	output logic             lb_write,     // Local cycle is a write.
	output logic      [31:0] lb_wdata,     // Local write data.
	input  wire logic [31:0] lb_rdata      // Local read data.
);
	import dma_chan_pkg::*;

	chan_regs_t q;
	chan_regs_t d;

	function automatic logic [2:0] xfer_len(input logic [1:0] a,
		input logic [6:0] room, input logic [`COUNT_W-1:0] left);
		logic [2:0] n;
		n = 3'h4 - {1'b0, a};
		if (room < 7'(n))
			n = room[2:0];
		if (left < `COUNT_W'(n))
			n = left[2:0];
		return n;
	endfunction : xfer_len

	function automatic logic [3:0] be_of(input logic [1:0] a,
		input logic [2:0] n);
		logic [3:0] be;
		for (int i = 0; i < 4; i++) begin
			be[i] = (i >= int'(a)) && (i < int'(a) + int'(n));
		end
		return be;
	endfunction : be_of

	function automatic logic [6:0] buf_idx(input logic half,
		input logic [6:0] off, input int i);
		return 7'({half, 6'h00}) + off + 7'(i);
	endfunction : buf_idx

	// Source lanes come from the bus that fills, destination from the other.
	function automatic logic [2:0] src_len(input chan_regs_t s);
		logic [1:0] a;
		a = s.ctrl[`CTL_DIR] ? s.caddr[1:0] : s.saddr[1:0];
		return xfer_len(a, `HALF_BYTES - s.src_off, s.left);
	endfunction : src_len

	function automatic logic [2:0] dst_len(input chan_regs_t s);
		logic [1:0] a;
		a = s.ctrl[`CTL_DIR] ? s.saddr[1:0] : s.caddr[1:0];
		return xfer_len(a, s.len[s.dst_half] - s.dst_off, {`COUNT_W{1'b1}});
	endfunction : dst_len

	function automatic logic [31:0] gather(input chan_regs_t s,
		input logic [1:0] a, input logic [2:0] n);
		logic [31:0] w;
		w = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			if (i < int'(n))
				w[(int'(a) + i) * 8 +: 8] =
					s.bytes[buf_idx(s.dst_half, s.dst_off, i)];
		end
		return w;
	endfunction : gather

	function automatic logic [31:0] status_of(input chan_regs_t s);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`STS_BUSY]     = s.st != ST_IDLE;
		w[`STS_TERM]     = s.tc_seen;
		w[`STS_APPENDED] = s.append_done;
		w[`STS_BUS_REQ]  = s.req;
		return w;
	endfunction : status_of

	logic        dir;
	logic        sys_owned;
	logic        src_ok;
	logic        dst_ok;
	logic        sys_fire;
	logic        lb_fire;
	logic        src_fire;
	logic        dst_fire;
	logic [2:0]  ns;
	logic [2:0]  nd;
	logic [2:0]  n_sys;
	logic [1:0]  sa;
	logic [31:0] src_word;
	logic        apb_wr;
	logic        mapped;

	assign dir = q.ctrl[`CTL_DIR];
	assign ns = src_len(q);
	assign nd = dst_len(q);
	assign n_sys = dir ? nd : ns;
	assign sa = dir ? q.caddr[1:0] : q.saddr[1:0];
	assign src_word = dir ? lb_rdata : sys_rdata;

	// A shared grant is only usable when both channels sit on one level.
	assign sys_owned = q.req
		&& (sys_gnt || (share_in && peer_level == q.ctrl[`CTL_LEVEL]));
	assign src_ok = q.st == ST_RUN && !q.full[q.src_half] && q.left != '0
		&& (dir || (sys_owned && q.tcnt < `TENURE_MIN));
	assign dst_ok = q.st == ST_RUN && q.full[q.dst_half]
		&& (!dir || sys_owned);
	assign sys_valid = (q.st == ST_RUN) ? (dir ? dst_ok : src_ok)
		: (q.st == ST_APPEND && sys_owned);
	assign lb_valid = (q.st == ST_RUN) ? (dir ? src_ok : dst_ok)
		: (q.st == ST_POST);
	assign sys_fire = sys_valid && sys_ready;
	assign lb_fire = lb_valid && lb_ready;
	assign src_fire = q.st == ST_RUN && (dir ? lb_fire : sys_fire);
	assign dst_fire = q.st == ST_RUN && (dir ? sys_fire : lb_fire);
	assign share_out = q.req && sys_gnt && q.st == ST_RUN && !sys_valid;
	assign level_out = q.ctrl[`CTL_LEVEL];
	assign sys_req = q.req;

	assign mapped = paddr == `OFF_CONTROL || paddr == `OFF_SYS_ADDR
		|| paddr == `OFF_CARD_ADDR || paddr == `OFF_BYTE_COUNT
		|| paddr == `OFF_TARGET_WORD || paddr == `OFF_STATUS;
	assign apb_wr = psel && penable && pwrite && mapped;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	assign prdata = q.prdata;
	assign sys_addr = q.sys_addr;
	assign sys_be = q.sys_be;
	assign sys_write = q.sys_write;
	assign sys_io = q.sys_io;
	assign sys_stream = q.sys_stream;
	assign sys_wdata = q.sys_wdata;
	assign lb_addr = q.lb_addr;
	assign lb_be = q.lb_be;
	assign lb_write = q.lb_write;
	assign lb_wdata = q.lb_wdata;

	always_comb begin
		logic finish;
		logic [2:0] os;
		logic [2:0] od;
		finish = 1'b0;
		os = 3'h0;
		od = 3'h0;
		d = q;

		if (src_fire) begin
			for (int i = 0; i < 4; i++) begin
				if (i < int'(ns))
					d.bytes[buf_idx(q.src_half, q.src_off, i)] =
						src_word[(int'(sa) + i) * 8 +: 8];
			end
			d.src_off = q.src_off + 7'(ns);
			d.left = q.left - `COUNT_W'(ns);
			if (dir)
				d.caddr = q.caddr + 32'(ns);
			else
				d.saddr = q.saddr + 32'(ns);
			// A half is handed over when full or when the count is spent.
			if (d.src_off == `HALF_BYTES || d.left == '0) begin
				d.full[q.src_half] = 1'b1;
				d.len[q.src_half] = d.src_off;
				d.src_half = ~q.src_half;
				d.src_off = 7'h00;
			end
		end

		// Draining the full half while the other fills is what lets local
		// writes overlap system reads and refills overlap system writes.
		if (dst_fire) begin
			d.dst_off = q.dst_off + 7'(nd);
			if (dir)
				d.saddr = q.saddr + 32'(nd);
			else
				d.caddr = q.caddr + 32'(nd);
			if (d.dst_off == q.len[q.dst_half]) begin
				d.full[q.dst_half] = 1'b0;
				d.dst_half = ~q.dst_half;
				d.dst_off = 7'h00;
			end
		end

		if (q.st == ST_RUN && sys_fire) begin
			d.tcnt = (q.tcnt >= `TENURE_MIN) ? q.tcnt : q.tcnt + 8'(n_sys);
			if (n_sys == 3'h4)
				d.aligned4 = 1'b1;
		end

		unique case (q.st)
			ST_IDLE: begin
			end
			ST_RUN: begin
				if (!dir) begin
					if (!q.req && q.left != '0 && q.full == 2'b00
						&& q.src_off == 7'h00) begin
						d.req = 1'b1;
						d.tcnt = 8'h00;
						d.aligned4 = 1'b0;
					end else if (q.req && (d.tcnt >= `TENURE_MIN
						|| d.left == '0)) begin
						d.req = 1'b0;
					end
				end else begin
					if (!q.req && (q.full == 2'b11
						|| (q.left == '0 && q.full != 2'b00))) begin
						d.req = 1'b1;
						d.tcnt = 8'h00;
						d.aligned4 = 1'b0;
					end else if (q.req && !d.full[d.dst_half]) begin
						d.req = 1'b0;
					end
				end
				// Terminal count waits for the destination to take the last byte.
				if (d.left == '0 && d.full == 2'b00 && d.src_off == 7'h00) begin
					d.tc_seen = 1'b1;
					d.req = 1'b0;
					if (q.ctrl[`CTL_APPEND] && !q.ctrl[`CTL_POST]) begin
						d.st = ST_APPEND;
						d.req = 1'b1;
					end else if (q.ctrl[`CTL_POST]) begin
						d.st = ST_POST;
					end else begin
						finish = 1'b1;
					end
				end
			end
			ST_APPEND: begin
				if (sys_fire) begin
					d.append_done = 1'b1;
					d.req = 1'b0;
					finish = 1'b1;
				end
			end
			ST_POST: begin
				if (lb_fire)
					finish = 1'b1;
			end
		endcase

		if (finish) begin
			d.st = ST_IDLE;
			d.ctrl[`CTL_ENABLE] = 1'b0;
		end

		// Setup phase latches read data so it is steady during access.
		if (psel && !penable) begin
			unique case (paddr)
				`OFF_CONTROL:     d.prdata = q.ctrl;
				`OFF_SYS_ADDR:    d.prdata = q.saddr;
				`OFF_CARD_ADDR:   d.prdata = q.caddr;
				`OFF_BYTE_COUNT:  d.prdata = 32'(q.left);
				`OFF_TARGET_WORD: d.prdata = q.target;
				`OFF_STATUS:      d.prdata = status_of(q);
				default:          d.prdata = 32'h0000_0000;
			endcase
		end

		// Descriptor words only change while idle; a running channel only
		// accepts a stop, so a transfer never sees its setup move under it.
		if (apb_wr) begin
			if (paddr == `OFF_CONTROL) begin
				if (q.st == ST_IDLE) begin
					d.ctrl = pwdata;
					if (pwdata[`CTL_ENABLE]) begin
						d.st = ST_RUN;
						d.full = 2'b00;
						d.src_half = 1'b0;
						d.dst_half = 1'b0;
						d.src_off = 7'h00;
						d.dst_off = 7'h00;
						d.tc_seen = 1'b0;
						d.append_done = 1'b0;
					end
				end else if (!pwdata[`CTL_ENABLE]) begin
					d.st = ST_IDLE;
					d.req = 1'b0;
					d.ctrl[`CTL_ENABLE] = 1'b0;
				end
			end else if (q.st == ST_IDLE) begin
				unique case (paddr)
					`OFF_SYS_ADDR:    d.saddr = pwdata;
					`OFF_CARD_ADDR:   d.caddr = pwdata;
					`OFF_BYTE_COUNT:  d.left = pwdata[`COUNT_W-1:0];
					`OFF_TARGET_WORD: d.target = pwdata;
					default: begin
					end
				endcase
			end
		end

		os = src_len(d);
		od = dst_len(d);
		if (d.st == ST_APPEND) begin
			d.sys_addr = {16'h0000, d.target[15:0]};
			d.sys_be = be_of(d.target[1:0], 3'h1);
			d.sys_wdata = {4{d.target[23:16]}};
		end else begin
			d.sys_addr = d.saddr;
			d.sys_be = be_of(d.saddr[1:0], d.ctrl[`CTL_DIR] ? od : os);
			d.sys_wdata = gather(d, d.saddr[1:0], od);
		end
		d.sys_io = d.st == ST_APPEND;
		d.sys_write = d.ctrl[`CTL_DIR] || d.st == ST_APPEND;
		d.sys_stream = d.st == ST_RUN && d.aligned4 && d.saddr[1:0] == 2'b00
			&& (d.ctrl[`CTL_DIR] ? od : os) == 3'h4;
		if (d.st == ST_POST) begin
			d.lb_addr = {d.target[31:2], 2'b00};
			d.lb_be = 4'hf;
			d.lb_wdata = status_of(d);
			d.lb_write = 1'b1;
		end else begin
			d.lb_addr = {d.caddr[31:2], 2'b00};
			d.lb_be = d.ctrl[`CTL_DIR] ? 4'hf : be_of(d.caddr[1:0], od);
			d.lb_wdata = gather(d, d.caddr[1:0], od);
			d.lb_write = !d.ctrl[`CTL_DIR];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.st <= ST_IDLE;
			q.ctrl <= `CONTROL_RST;
			q.saddr <= `ADDR_RST;
			q.caddr <= `ADDR_RST;
			q.left <= `COUNT_RST;
			q.lb_be <= 4'hf;
		end else begin
			q <= d;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_half_len: assert property (q.len[0] <= `HALF_BYTES
		&& q.len[1] <= `HALF_BYTES) else $error("half length above 64");
	a_first_tenure: assert property ($fell(q.req) && q.st == ST_RUN
		&& !dir |-> q.tcnt >= `TENURE_MIN || q.left == '0)
		else $error("system read released before 128 bytes");
	a_prefetch: assert property ($rose(q.req) && q.st == ST_RUN && dir
		|-> q.full == 2'b11 || q.left == '0)
		else $error("arbitrated before prefetch done");
	a_start_arb: assert property ($rose(q.st == ST_RUN) && !dir
		&& q.left != '0 |=> q.req) else $error("no immediate arbitration");
	a_count_dec: assert property (src_fire && !apb_wr
		|=> q.left == $past(q.left) - `COUNT_W'($past(ns)))
		else $error("byte count not reduced by source bytes");
	a_sys_addr_adv: assert property (q.st == ST_RUN && sys_fire
		&& !apb_wr |=> q.saddr == $past(q.saddr) + 32'($past(n_sys)))
		else $error("system address did not advance");
	a_lb_read_word: assert property (lb_valid && !lb_write
		|-> lb_be == 4'hf && lb_addr[1:0] == 2'b00)
		else $error("local read not a whole word");
	a_lb_odd_write: assert property (lb_valid && lb_write && q.st == ST_RUN
		&& q.caddr[1:0] == 2'b01 && nd == 3'h3 |-> lb_be == 4'he)
		else $error("odd local write not on upper lanes");
	a_sys_three: assert property (sys_valid && !sys_io
		&& sys_addr[1:0] == 2'b01 && q.left >= `COUNT_W'(3) && !dir
		|-> sys_be == 4'he) else $error("offset 1 cycle not three bytes");
	a_stream_align: assert property (sys_valid && sys_stream
		|-> sys_addr[1:0] == 2'b00 && sys_be == 4'hf && q.aligned4)
		else $error("stream cycle not aligned");
	a_append_io: assert property (sys_valid && sys_io
		|-> sys_addr[15:0] == q.target[15:0] && sys_write
		&& sys_wdata[31:24] == q.target[23:16])
		else $error("appended write address or data wrong");
	a_append_gate: assert property (q.st == ST_APPEND
		|-> q.ctrl[`CTL_APPEND] && !q.ctrl[`CTL_POST] && q.full == 2'b00)
		else $error("appended write with post-status or data left");

endmodule : dma_chan

// ---- rtl/dma_chan_map.svh ----
`ifndef DMA_CHAN_MAP_SVH
`define DMA_CHAN_MAP_SVH

// Register byte offsets on the APB window.
`define OFF_CONTROL      12'h000
`define OFF_SYS_ADDR     12'h004
`define OFF_CARD_ADDR    12'h008
`define OFF_BYTE_COUNT   12'h00c
`define OFF_TARGET_WORD  12'h010
`define OFF_STATUS       12'h014

// Channel control word bit positions.
`define CTL_ENABLE       0
`define CTL_DIR          1
`define CTL_APPEND       7
`define CTL_POST         8
`define CTL_LEVEL        9

// Status word bit positions.
`define STS_BUSY         0
`define STS_TERM         1
`define STS_APPENDED     2
`define STS_BUS_REQ      3

`define CONTROL_RST      32'h0000_0000
`define ADDR_RST         32'h0000_0000
`define COUNT_RST        24'h00_0000
`define COUNT_W          24

// Staging buffer geometry and the least bytes per first tenure.
`define BUF_BYTES        128
`define HALF_BYTES       7'h40
`define TENURE_MIN       8'h80

`endif

// ---- rtl/dma_chan_pkg.sv ----
`include "dma_chan_map.svh"

package dma_chan_pkg;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_RUN    = 2'b01,
		ST_APPEND = 2'b10,
		ST_POST   = 2'b11
	} chan_state_t;

	typedef struct packed {
		chan_state_t                      st;
		logic [31:0]                      ctrl;
		logic [31:0]                      saddr;
		logic [31:0]                      caddr;
		logic [31:0]                      target;
		logic [`COUNT_W-1:0]              left;
		logic                             tc_seen;
		logic                             append_done;
		logic [1:0]                       full;
		logic [1:0][6:0]                  len;
		logic                             src_half;
		logic                             dst_half;
		logic [6:0]                       src_off;
		logic [6:0]                       dst_off;
		logic                             req;
		logic [7:0]                       tcnt;
		logic                             aligned4;
		logic [`BUF_BYTES-1:0][7:0]       bytes;
		logic [31:0]                      prdata;
		logic [31:0]                      sys_addr;
		logic [31:0]                      sys_wdata;
		logic [3:0]                       sys_be;
		logic                             sys_io;
		logic                             sys_write;
		logic                             sys_stream;
		logic [31:0]                      lb_addr;
		logic [31:0]                      lb_wdata;
		logic [3:0]                       lb_be;
		logic                             lb_write;
	} chan_regs_t;

endpackage : dma_chan_pkg

// ---- test/dma_far_side.sv ----
`timescale 1ns/1ps
// Arbiter, system slave and local memory seen from the channel.
module dma_far_side (
	input  wire logic        pclk,       // Clock.
	input  wire logic        presetn,    // Reset, active low.
	input  wire logic        slow,       // Stretch answers.
	input  wire logic        clr,        // Clear statistics.
	input  wire logic        sys_req,    // Request.
	output logic             sys_gnt,    // Grant.
	input  wire logic        sys_valid,  // System cycle.
	output logic             sys_ready,  // System done.
	input  wire logic [31:0] sys_addr,   // System address.
	input  wire logic [3:0]  sys_be,     // System enables.
	input  wire logic        sys_write,  // System write.
	input  wire logic        sys_io,     // I/O cycle.
	input  wire logic        sys_stream, // Streaming.
	input  wire logic [31:0] sys_wdata,  // System data out.
	output logic      [31:0] sys_rdata,  // System data in.
	input  wire logic        lb_valid,   // Local cycle.
	output logic             lb_ready,   // Local done.
	input  wire logic [31:0] lb_addr,    // Local address.
	input  wire logic [3:0]  lb_be,      // Local enables.
	input  wire logic        lb_write,   // Local write.
	input  wire logic [31:0] lb_wdata,   // Local data out.
	output logic      [31:0] lb_rdata    // Local data in.
);
	logic [7:0]  lmem [256];
	logic [7:0]  smem [256];
	logic [3:0]  sbe [3];
	logic        sstr [3];
	logic [3:0]  lbe1, io_be;
	logic [31:0] io_data, lb_last, sq, lq;
	logic [15:0] io_addr;
	logic [1:0]  tick;
	logic        req_q, first, last_io, bad_rd;
	int          ncyc, ten1, rises, sbytes, lbytes, lwr, pre_words, io_cnt;

	function automatic logic [31:0] pat(input logic [31:0] a, input logic l);
		logic [31:0] w;
		logic [7:0]  b;
		for (int i = 0; i < 4; i++) begin
			b = {a[7:2], 2'b00} + 8'(i);
			w[8*i+:8] = l ? b + 8'h11 : b ^ 8'h3c;
		end
		return w;
	endfunction : pat

	function automatic int pc(input logic [3:0] be);
		return be[0] + be[1] + be[2] + be[3];
	endfunction : pc

	// The local side is the slower one when stretched, so buffers fill up.
	assign sys_ready = !slow || tick[0];
	assign lb_ready  = !slow || tick == 2'b00;
	// A released data bus shows the inverse of its last value.
	assign sys_rdata = (sys_valid && !sys_write) ? pat(sys_addr, 1'b0) : ~sq;
	assign lb_rdata  = (lb_valid && !lb_write) ? pat(lb_addr, 1'b1) : ~lq;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_gnt <= 1'b0;
			tick    <= 2'h0;
			req_q   <= 1'b0;
			sq      <= 32'h0;
			lq      <= 32'h0;
		end else begin
			tick    <= tick + 2'h1;
			sys_gnt <= sys_req;
			req_q   <= sys_req;
			sq      <= sys_valid ? sys_rdata : sq;
			lq      <= lb_valid ? lb_rdata : lq;
		end
	end

	always @(posedge pclk) begin
		if (clr) begin
			{ncyc, ten1, rises, sbytes, lbytes, lwr, pre_words, io_cnt} = '0;
			first = 1'b1;
			bad_rd = 1'b0;
		end else begin
			if (sys_req && !req_q)
				rises++;
			if (!sys_req && req_q)
				first = 1'b0;
			if (sys_valid && sys_ready) begin
				last_io = sys_io;
				if (sys_io) begin
					io_cnt++;
					io_addr = sys_addr[15:0];
					io_data = sys_wdata;
					io_be = sys_be;
				end else begin
					sbytes += pc(sys_be);
					ten1 += first ? pc(sys_be) : 0;
					if (ncyc < 3) begin
						sbe[ncyc] = sys_be;
						sstr[ncyc] = sys_stream;
					end
					ncyc++;
					for (int i = 0; i < 4; i++)
						if (sys_write && sys_be[i])
							smem[{sys_addr[7:2], 2'b00} + 8'(i)] = sys_wdata[8*i+:8];
				end
			end
			if (lb_valid && lb_ready) begin
				if (lb_write) begin
					lbe1 = (lwr == 0) ? lb_be : lbe1;
					lwr++;
					lbytes += pc(lb_be);
					lb_last = lb_addr;
					for (int i = 0; i < 4; i++)
						if (lb_be[i])
							lmem[lb_addr[7:0] + 8'(i)] = lb_wdata[8*i+:8];
				end else begin
					bad_rd |= lb_be != 4'hf || lb_addr[1:0] != 2'b00;
					pre_words += (rises == 0) ? 1 : 0;
				end
			end
		end
	end
endmodule : dma_far_side

// ---- test/bus_master_dma_channel_buffering_bench.sv ----
`timescale 1ns/1ps
`include "dma_chan_map.svh"
module bus_master_dma_channel_buffering_bench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, sys_addr, sys_wdata, sys_rdata, r;
	logic [31:0] lb_addr, lb_wdata, lb_rdata;
	logic [3:0]  sys_be, lb_be;
	logic        sys_req, sys_gnt, sys_valid, sys_ready, sys_write, sys_io;
	logic        sys_stream, share_out, level_out, lb_valid, lb_ready;
	logic        lb_write, slow, clr, e, share_in, peer_level;
	int          num_errors, comparisons, cycles, shared;

	dma_chan i_dma_chan (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .sys_req, .sys_gnt, .sys_valid,
		.sys_ready, .sys_addr, .sys_be, .sys_write, .sys_io, .sys_stream,
		.sys_wdata, .sys_rdata, .share_out, .share_in, .level_out,
		.peer_level, .lb_valid, .lb_ready, .lb_addr, .lb_be, .lb_write,
		.lb_wdata, .lb_rdata);

	dma_far_side i_dma_far_side (.pclk, .presetn, .slow, .clr, .sys_req,
		.sys_gnt, .sys_valid, .sys_ready, .sys_addr, .sys_be, .sys_write,
		.sys_io, .sys_stream, .sys_wdata, .sys_rdata, .lb_valid, .lb_ready,
		.lb_addr, .lb_be, .lb_write, .lb_wdata, .lb_rdata);

	task end_of_test;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_of_test

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic er);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task run(input logic [31:0] ctl, sa, ca, cnt, tg);
		int n;
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		apb(1'b1, `OFF_SYS_ADDR, sa, r, e);
		apb(1'b1, `OFF_CARD_ADDR, ca, r, e);
		apb(1'b1, `OFF_BYTE_COUNT, cnt, r, e);
		apb(1'b1, `OFF_TARGET_WORD, tg, r, e);
		apb(1'b1, `OFF_CONTROL, ctl, r, e);
		repeat (4) @(posedge pclk);
		n = 0;
		do begin
			apb(1'b0, `OFF_STATUS, 32'h0, r, e);
			n++;
		end while (r[`STS_BUSY] !== 1'b0 && n < 3000);
		chk({31'h0, r[`STS_TERM]}, 32'h1);
	endtask : run

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// Ceiling well above the several hundred cycles the five transfers take.
	always @(posedge pclk) begin
		cycles++;
		// Cycles in which the channel runs on borrowed grant time.
		shared = clr ? 0 : shared + int'(sys_valid && !sys_gnt);
		if (cycles == 80000) begin
			num_errors++;
			end_of_test();
		end
	end

	initial begin
		{presetn, psel, penable, pwrite, slow, share_in, peer_level} = '0;
		{paddr, pwdata} = '0;
		clr = 1'b1;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		clr     <= 1'b0;
		for (int a = 0; a < 24; a += 4) begin
			apb(1'b0, 12'(a), 32'h0, r, e);
			chk(r, 32'h0);
		end
		apb(1'b0, 12'h018, 32'h0, r, e);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
		apb(1'b1, `OFF_CONTROL, 32'h2, r, e);
		repeat (20) @(posedge pclk);
		chk(i_dma_far_side.rises + i_dma_far_side.lwr, 0);
		// Read from the system side, odd addresses, slow local memory.
		slow <= 1'b1;
		run(32'h1, 32'h1, 32'h21, 32'd200, 32'h0);
		chk(i_dma_far_side.sbe[0], 4'he);
		chk({i_dma_far_side.sbe[1], 3'h0, i_dma_far_side.sstr[1]}, 8'hf0);
		chk(i_dma_far_side.sstr[2], 1);
		chk(i_dma_far_side.lbe1, 4'he);
		chk(i_dma_far_side.ten1 >= 128, 1);
		chk(i_dma_far_side.rises >= 2, 1);
		chk(i_dma_far_side.sbytes, 200);
		chk(i_dma_far_side.lbytes, 200);
		chk(i_dma_far_side.io_cnt, 0);
		for (int i = 0; i < 200; i++)
			chk(i_dma_far_side.lmem[8'h21 + i], 8'(1 + i) ^ 8'h3c);
		apb(1'b0, `OFF_SYS_ADDR, 32'h0, r, e);
		chk(r, 32'd201);
		apb(1'b0, `OFF_CARD_ADDR, 32'h0, r, e);
		chk(r, 32'h21 + 32'd200);
		apb(1'b0, `OFF_BYTE_COUNT, 32'h0, r, e);
		chk(r, 32'h0);
		apb(1'b0, `OFF_CONTROL, 32'h0, r, e);
		chk({31'h0, r[`CTL_ENABLE]}, 32'h0);
		// Write to the system side with the appended I/O write.
		slow <= 1'b0;
		run(32'h83, 32'h10, 32'h1, 32'd200, 32'h00ab_0345);
		chk(i_dma_far_side.pre_words >= 32, 1);
		chk(i_dma_far_side.bad_rd, 0);
		chk(i_dma_far_side.io_cnt, 1);
		chk(i_dma_far_side.io_addr, 16'h0345);
		chk({i_dma_far_side.io_be, i_dma_far_side.io_data[15:8]}, 12'h2ab);
		chk(i_dma_far_side.last_io, 1);
		for (int i = 0; i < 200; i++)
			chk(i_dma_far_side.smem[8'h10 + i], 8'(1 + i) + 8'h11);
		// Append and post-status together: status posted, no I/O write.
		run(32'h181, 32'h0, 32'h0, 32'd8, 32'h80);
		chk(i_dma_far_side.io_cnt, 0);
		chk(i_dma_far_side.lb_last, 32'h80);
		chk(i_dma_far_side.lmem[8'h80], 8'h03);
		for (int i = 0; i < 8; i++)
			chk(i_dma_far_side.lmem[i], 8'(i) ^ 8'h3c);
		// Peer grant time counts only when both level options agree.
		share_in   <= 1'b1;
		peer_level <= 1'b1;
		run(32'h201, 32'h0, 32'h40, 32'd8, 32'h0);
		chk(shared != 0, 1);
		chk(level_out, 1);
		run(32'h1, 32'h0, 32'h40, 32'd8, 32'h0);
		chk(shared, 0);
		chk(level_out, 0);
		end_of_test();
	end
endmodule : bus_master_dma_channel_buffering_bench
